//--- core/adc_output_format.sv
// Output formatting, test patterns and fine gain of the converter output.
// Assumes an APB master on pclk and a free-running sample clock that also
// clocks the converter samples and the capture logic at the output.
//
// Function
// - Pattern selector picks samples or test patterns
// - Format bit picks two's complement or offset
// - Bit-wise: odd bits rise, even bits fall
// - Byte-wise: low 7 rise, upper 5 fall
// - Pairing applies only with DDR LVDS interface
// - Fine gain is code times 0.5 dB for codes 0 to 12; codes 13 to 15 give unity gain
// - Fine gain code resets to zero
// - Low register bits 7..2 hold pattern low
// - High register bits 5..0 hold pattern high
// - Interface bit selects CMOS or DDR LVDS
//
// The APB interface to the registers was decided locally.
module adc_output_format
    import adc_fmt_pkg::*;
(
    input  wire logic        pclk,          // Register clock
    input  wire logic        presetn,       // Asynchronous reset, low active
    input  wire logic        psel,          // APB select
    input  wire logic        penable,       // APB access phase
    input  wire logic        pwrite,        // APB direction
    input  wire logic [11:0] paddr,         // APB byte address
    input  wire logic [31:0] pwdata,        // APB write data
    input  wire logic [3:0]  pstrb,         // APB byte strobes
    output logic      [31:0] prdata,        // APB read data
    output logic             pready,        // APB ready
    output logic             pslverr,       // APB error on unmapped address
    input  wire logic        sample_clk,    // Sample clock
    input  wire logic [11:0] sample_in,     // Converter samples, offset binary
    output logic      [11:0] cmos_data,     // Parallel data word
    output logic      [6:0]  lvds_rise,     // Lanes for output_strobe rising edge
    output logic      [6:0]  lvds_fall,     // Lanes for output_strobe falling edge
    output logic             output_strobe  // High while output words are valid
);
    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------
    logic             iface_r;
    logic             fmt_r;
    logic             pair_r;
    logic [2:0]       pat_r;
    logic [3:0]       gain_r;
    logic [5:0]       usr_lo_r;
    logic [5:0]       usr_hi_r;
    logic [7:0]       idx;
    logic             aligned;
    logic             hit;
    logic             wr_en;
    logic [31:0]      rd_nxt;
    logic [CFG_W-1:0] cfg_live;
    logic [CFG_W-1:0] cfg_snap_r;
    logic             req_r;
    logic             ack_s1_r;
    logic             ack_s2_r;
    logic             ack_s3_r;
    logic             busy_r;
    logic             ack_r;

    assign idx     = paddr[9:2];
    assign aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign wr_en   = psel && penable && pready && pwrite && !pslverr && pstrb[0];

    always_comb
    begin
        hit    = aligned;
        rd_nxt = 32'h0000_0000;
        if (idx == IDX_IFACE)
            rd_nxt[IFACE_BIT] = iface_r;
        else if (idx == IDX_FORMAT)
        begin
            rd_nxt[FMT_BIT]  = fmt_r;
            rd_nxt[PAIR_BIT] = pair_r;
            rd_nxt[2:0]      = pat_r;
        end
        else if (idx == IDX_GAIN)
            rd_nxt[3:0] = gain_r;
        else if (idx == IDX_USR_LO)
            rd_nxt[7:2] = usr_lo_r;
        else if (idx == IDX_USR_HI)
            rd_nxt[5:0] = usr_hi_r;
        else if (idx == IDX_STATUS)
            rd_nxt[0] = busy_r || (cfg_live != cfg_snap_r);
        else
            hit = 1'b0;
    end

    // ------------------------------------------------------------------
    // APB answer: ready in the first access cycle
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable && !pwrite && hit)
                prdata <= rd_nxt;
            else
                prdata <= 32'h0000_0000;
        end
    end

    // Fixed-zero bits are not stored and read back as zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            iface_r  <= 1'b0;
            fmt_r    <= 1'b0;
            pair_r   <= 1'b0;
            pat_r    <= PAT_RESET;
            gain_r   <= GAIN_RESET;
            usr_lo_r <= USR_RESET;
            usr_hi_r <= USR_RESET;
        end
        else if (wr_en)
        begin
            if (idx == IDX_IFACE)
                iface_r <= pwdata[IFACE_BIT];
            else if (idx == IDX_FORMAT)
            begin
                fmt_r  <= pwdata[FMT_BIT];
                pair_r <= pwdata[PAIR_BIT];
                pat_r  <= pwdata[2:0];
            end
            else if (idx == IDX_GAIN)
                gain_r <= pwdata[3:0];
            else if (idx == IDX_USR_LO)
                usr_lo_r <= pwdata[7:2];
            else if (idx == IDX_USR_HI)
                usr_hi_r <= pwdata[5:0];
        end
    end

    // ------------------------------------------------------------------
    // Configuration crossing: snapshot held stable while request is open
    // ------------------------------------------------------------------
    assign cfg_live = {iface_r, fmt_r, pair_r, pat_r, gain_r, usr_hi_r, usr_lo_r};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
            ack_s3_r <= 1'b0;
        end
        else
        begin
            ack_s1_r <= ack_r;
            ack_s2_r <= ack_s1_r;
            ack_s3_r <= ack_s2_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_snap_r <= '0;
            req_r      <= 1'b0;
            busy_r     <= 1'b0;
        end
        else if (!busy_r)
        begin
            if (cfg_live != cfg_snap_r)
            begin
                cfg_snap_r <= cfg_live;
                req_r      <= !req_r;
                busy_r     <= 1'b1;
            end
        end
        else if (ack_s2_r != ack_s3_r)
            busy_r <= 1'b0;
    end

    // ------------------------------------------------------------------
    // Sample domain reset and request synchroniser
    // ------------------------------------------------------------------
    logic             rst_s1_r;
    logic             srst_n;
    logic             req_s1_r;
    logic             req_s2_r;
    logic             req_s3_r;
    logic [CFG_W-1:0] cfg_s_r;

    always_ff @(posedge sample_clk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_s1_r <= 1'b0;
            srst_n   <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            srst_n   <= rst_s1_r;
        end
    end

    always_ff @(posedge sample_clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            req_s1_r <= 1'b0;
            req_s2_r <= 1'b0;
            req_s3_r <= 1'b0;
            ack_r    <= 1'b0;
            cfg_s_r  <= '0;
        end
        else
        begin
            req_s1_r <= req_r;
            req_s2_r <= req_s1_r;
            req_s3_r <= req_s2_r;
            if (req_s2_r != req_s3_r)
            begin
                cfg_s_r <= cfg_snap_r;
                ack_r   <= req_s2_r;
            end
        end
    end

    logic        s_iface;
    logic        s_fmt;
    logic        s_pair;
    logic [2:0]  s_pat;
    logic [3:0]  s_gain;
    logic [11:0] s_user;
    assign {s_iface, s_fmt, s_pair, s_pat, s_gain, s_user} = cfg_s_r;
    // ------------------------------------------------------------------
    // Stage 1: fine gain on the centred sample, saturated to 12 bits
    // ------------------------------------------------------------------
    logic signed [11:0] centred;
    logic signed [26:0] product;
    logic signed [14:0] scaled;
    logic signed [11:0] gained_r;
    logic               valid_r;
    assign centred = $signed({~sample_in[11], sample_in[10:0]});
    assign product = centred * $signed({1'b0, gain_factor(s_gain)});
    assign scaled  = product[26:12];

    always_ff @(posedge sample_clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            gained_r <= 12'sh000;
            valid_r  <= 1'b0;
        end
        else
        begin
            valid_r <= 1'b1;
            if (scaled > 15'sd2047)
                gained_r <= 12'sh7ff;
            else if (scaled < -15'sd2048)
                gained_r <= 12'sh800;
            else
                gained_r <= scaled[11:0];
        end
    end

    // ------------------------------------------------------------------
    // Stage 2: pattern select, coding and lane pairing
    // ------------------------------------------------------------------
    logic [11:0] word;
    logic [11:0] ramp_r;
    logic        tog_r;
    logic [6:0]  rise_nxt;
    logic [6:0]  fall_nxt;

    always_comb
    begin
        case (pattern_t'(s_pat))
            PAT_SAMPLES: word = s_fmt ? {~gained_r[11], gained_r[10:0]}
                                      : gained_r;
            PAT_ZEROS:   word = 12'h000;
            PAT_ONES:    word = 12'hfff;
            PAT_TOGGLE:  word = tog_r ? TOGGLE_B : TOGGLE_A;
            PAT_RAMP:    word = ramp_r;
            PAT_USER:    word = s_user;
            default:     word = 12'h000;
        endcase
    end

    always_comb
    begin
        if (s_pair)
        begin
            rise_nxt = word[6:0];
            fall_nxt = {2'b00, word[11:7]};
        end
        else
        begin
            rise_nxt = {1'b0, word[11], word[9], word[7], word[5], word[3], word[1]};
            fall_nxt = {1'b0, word[10], word[8], word[6], word[4], word[2], word[0]};
        end
    end

    always_ff @(posedge sample_clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            ramp_r <= 12'h000;
            tog_r  <= 1'b0;
        end
        else
        begin
            ramp_r <= ramp_r + 12'h001;
            tog_r  <= !tog_r;
        end
    end

    always_ff @(posedge sample_clk or negedge srst_n)
    begin
        if (!srst_n)
        begin
            cmos_data     <= 12'h000;
            lvds_rise     <= 7'h00;
            lvds_fall     <= 7'h00;
            output_strobe <= 1'b0;
        end
        else
        begin
            output_strobe <= valid_r;
            cmos_data     <= s_iface ? 12'h000 : word;
            lvds_rise     <= s_iface ? rise_nxt : 7'h00;
            lvds_fall     <= s_iface ? fall_nxt : 7'h00;
        end
    end
endmodule // adc_output_format

//--- include/adc_fmt_pkg.sv
// Package for the output formatting block of a dual-channel 12-bit converter.
// Assumes APB register access at 40 MHz and a separate sample clock domain.
package adc_fmt_pkg;
    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_IFACE   = 8'h14;
    localparam logic [7:0] IDX_FORMAT  = 8'h16;
    localparam logic [7:0] IDX_GAIN    = 8'h17;
    localparam logic [7:0] IDX_USR_LO  = 8'h18;
    localparam logic [7:0] IDX_USR_HI  = 8'h19;
    localparam logic [7:0] IDX_STATUS  = 8'h20;
    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int IFACE_BIT    = 5;
    localparam int FMT_BIT      = 4;
    localparam int PAIR_BIT     = 3;
    localparam int PAT_LSB      = 0;
    localparam int USR_LO_LSB   = 2;
    localparam int USR_HI_LSB   = 0;
    localparam int DATA_W       = 12;
    localparam int LANE_W       = 7;
    localparam int CFG_W        = 22;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [2:0]  PAT_RESET   = 3'h0;
    localparam logic [3:0]  GAIN_RESET  = 4'h0;
    localparam logic [5:0]  USR_RESET   = 6'h00;
    localparam logic [11:0] TOGGLE_A    = 12'haaa;
    localparam logic [11:0] TOGGLE_B    = 12'h555;
    localparam logic [3:0]  GAIN_MAX    = 4'hc;
    localparam int          GAIN_FRAC   = 12;

    typedef enum logic [2:0] {
        PAT_SAMPLES = 3'b000,
        PAT_ZEROS   = 3'b001,
        PAT_ONES    = 3'b010,
        PAT_TOGGLE  = 3'b011,
        PAT_RAMP    = 3'b100,
        PAT_USER    = 3'b101
    } pattern_t;

    // Gain factor for code*0.5 dB up to code 12, unity for codes 0 and 13 to 15; unity is 1 << GAIN_FRAC
    function automatic logic [13:0] gain_factor(input logic [3:0] code);
        case (code)
            4'h1:    gain_factor = 14'd4339;
            4'h2:    gain_factor = 14'd4596;
            4'h3:    gain_factor = 14'd4868;
            4'h4:    gain_factor = 14'd5157;
            4'h5:    gain_factor = 14'd5462;
            4'h6:    gain_factor = 14'd5786;
            4'h7:    gain_factor = 14'd6129;
            4'h8:    gain_factor = 14'd6492;
            4'h9:    gain_factor = 14'd6876;
            4'ha:    gain_factor = 14'd7284;
            4'hb:    gain_factor = 14'd7715;
            4'hc:    gain_factor = 14'd8173;
            default: gain_factor = 14'd4096;
        endcase
    endfunction
endpackage

//--- testbench/adc_output_format_assertions.sv
// Checker for the output format block, bound to its top module.
// Assumes the top module's ports only; no internal signals are used.
module adc_output_format_checker
    import adc_fmt_pkg::*;
(
    input wire logic        pclk,          // Register clock
    input wire logic        presetn,       // Reset, low active
    input wire logic        psel,          // APB select
    input wire logic        penable,       // APB access phase
    input wire logic        pwrite,        // APB direction
    input wire logic [11:0] paddr,         // APB address
    input wire logic [31:0] pwdata,        // APB write data
    input wire logic [3:0]  pstrb,         // APB strobes
    input wire logic [31:0] prdata,        // APB read data
    input wire logic        pready,        // APB ready
    input wire logic        pslverr,       // APB error
    input wire logic        sample_clk,    // Sample clock
    input wire logic [11:0] sample_in,     // Samples
    input wire logic [11:0] cmos_data,     // Parallel word
    input wire logic [6:0]  lvds_rise,     // Rising lanes
    input wire logic [6:0]  lvds_fall,     // Falling lanes
    input wire logic        output_strobe  // Words valid
);
    logic mapped;
    assign mapped = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00 && (paddr[9:2] inside
        {IDX_IFACE, IDX_FORMAT, IDX_GAIN, IDX_USR_LO, IDX_USR_HI, IDX_STATUS});

    a_ready_setup: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable |=> pready) else $error("no ready after setup");
    a_ready_single: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready) else $error("ready held too long");
    a_err_decode: assert property (@(posedge pclk) disable iff (!presetn)
        pready |-> pslverr == !mapped) else $error("error flag wrong for address");
    a_idle_rdata: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && penable) |-> prdata == 32'h0) else $error("read data outside access");
    a_fmt_fixed: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite && paddr[9:2] == IDX_FORMAT |-> prdata[31:5] == 27'h0)
        else $error("format fixed bits not zero");
    a_gain_width: assert property (@(posedge pclk) disable iff (!presetn)
        pready && !pwrite && paddr[9:2] == IDX_GAIN |-> prdata[31:4] == 28'h0)
        else $error("gain fixed bits not zero");
    a_lane_exclusive: assert property (@(posedge sample_clk) disable iff (!presetn)
        lvds_rise != 7'h00 || lvds_fall != 7'h00 |-> cmos_data == 12'h000)
        else $error("both interfaces active");
    a_fall_top: assert property (@(posedge sample_clk) disable iff (!presetn)
        output_strobe |-> lvds_fall[6] == 1'b0) else $error("falling lanes too wide");
    a_strobe_start: assert property (@(posedge sample_clk) disable iff (!presetn)
        $rose(presetn) |-> ##[1:4] output_strobe) else $error("strobe late after reset");
    a_strobe_holds: assert property (@(posedge sample_clk) disable iff (!presetn)
        output_strobe |=> output_strobe[*3]) else $error("strobe dropped");
endmodule // adc_output_format_checker

bind adc_output_format adc_output_format_checker chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_clk(sample_clk), .sample_in(sample_in),
    .cmos_data(cmos_data), .lvds_rise(lvds_rise), .lvds_fall(lvds_fall),
    .output_strobe(output_strobe));

//--- testbench/adc_capture_model.sv
// Capture logic at the far side of the output bus.
// Assumes words stand for one sample_clk period while the strobe is high.
module adc_capture_model
(
    input  wire logic        sample_clk,    // Sample clock
    input  wire logic        output_strobe, // Words valid
    input  wire logic [11:0] cmos_data,     // Parallel word
    input  wire logic [6:0]  lvds_rise,     // Rising lanes
    input  wire logic [6:0]  lvds_fall,     // Falling lanes
    output logic      [11:0] cap_cmos,      // Last word
    output logic      [6:0]  cap_rise,      // Last rising lanes
    output logic      [6:0]  cap_fall       // Last falling lanes
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge sample_clk)
    begin
        if (output_strobe)
        begin
            cap_cmos <= cmos_data;
            cap_rise <= lvds_rise;
            cap_fall <= lvds_fall;
        end
    end
endmodule // adc_capture_model

//--- testbench/tb_adc_output_format_test_gain.sv
// Self-checking bench for the output format block.
// Assumes the capture model at the output and APB access from this bench.
module tb_adc_output_format_test_gain
    import adc_fmt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] USR_P = 12'hb4d;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, sample_in = 12'h000, sample_val = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    logic        sample_clk = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, output_strobe;
    logic [11:0] cmos_data, cap_cmos;
    logic [6:0]  lvds_rise, lvds_fall, cap_rise, cap_fall;
    int          num_errors = 0, checks = 0, cycles = 0;

    always #12.5 pclk = ~pclk;
    initial
    begin
        #3;
        forever #16 sample_clk = ~sample_clk;
    end
    always @(posedge sample_clk) sample_in <= sample_val;

    adc_output_format uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sample_clk(sample_clk), .sample_in(sample_in),
        .cmos_data(cmos_data), .lvds_rise(lvds_rise), .lvds_fall(lvds_fall),
        .output_strobe(output_strobe));
    adc_capture_model cap (.sample_clk(sample_clk), .output_strobe(output_strobe),
        .cmos_data(cmos_data), .lvds_rise(lvds_rise), .lvds_fall(lvds_fall),
        .cap_cmos(cap_cmos), .cap_rise(cap_rise), .cap_fall(cap_fall));

    task automatic end_of_test();
        if (num_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            end_of_test();
        end
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // --------------------------------------------------------------
    // APB master: holds the request until pready is sampled high
    // --------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, wd};
        pstrb   <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n == 50)
            num_errors++;
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wreg(input logic [7:0] idx, input logic [7:0] v);
        logic [31:0] rd;
        logic        e;
        apb(1'b1, idx, v, rd, e);
    endtask
    task automatic rreg(input string nm, input logic [7:0] idx, input logic [31:0] x);
        logic [31:0] rd;
        logic        e;
        apb(1'b0, idx, 8'h00, rd, e);
        check(nm, rd, x);
    endtask
    // Waits for the configuration crossing, then for data to flow
    task automatic settle();
        logic [31:0] rd;
        logic        e;
        int          n;
        n = 0;
        do
        begin
            apb(1'b0, IDX_STATUS, 8'h00, rd, e);
            n++;
        end
        while (rd[0] !== 1'b0 && n < 50);
        if (n == 50)
            num_errors++;
        repeat (6) @(posedge sample_clk);
        #1;
    endtask
    task automatic cmos_case(input string nm, input logic [7:0] f, input logic [11:0] x);
        wreg(IDX_FORMAT, f);
        settle();
        check(nm, {20'h0, cap_cmos}, {20'h0, x});
    endtask
    function automatic logic [13:0] lanes(input logic [11:0] p, input logic byw);
        logic [6:0] r;
        logic [6:0] f;
        r = 7'h00;
        f = 7'h00;
        for (int i = 0; i < 6; i++)
        begin
            r[i] = p[2*i+1];
            f[i] = p[2*i];
        end
        if (byw)
        begin
            r = p[6:0];
            f = {2'b00, p[11:7]};
        end
        return {r, f};
    endfunction

    initial
    begin
        logic [31:0] rd;
        logic        e;
        logic [11:0] a, b;
        logic [13:0] ex;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rreg("gain_reset", IDX_GAIN, 32'h0);
        rreg("format_reset", IDX_FORMAT, 32'h0);
        apb(1'b1, 8'h15, 8'h5a, rd, e);
        check("unmapped_err", {31'h0, e}, 32'h1);
        wreg(IDX_GAIN, 8'h0c);
        rreg("gain_max", IDX_GAIN, 32'h0c);
        wreg(IDX_GAIN, 8'h00);
        wreg(IDX_USR_LO, {USR_P[5:0], 2'b00});
        wreg(IDX_USR_HI, {2'b00, USR_P[11:6]});
        rreg("usr_low", IDX_USR_LO, {24'h0, USR_P[5:0], 2'b00});
        rreg("usr_high", IDX_USR_HI, {26'h0, USR_P[11:6]});
        sample_val = 12'h123;
        cmos_case("pat_zeros", 8'h01, 12'h000);
        cmos_case("pat_ones", 8'h02, 12'hfff);
        cmos_case("pat_user", 8'h0d, USR_P);
        cmos_case("pat_unused", 8'h07, 12'h000);
        cmos_case("adc_binary", 8'h10, 12'h123);
        cmos_case("adc_twos", 8'h00, 12'h923);
        wreg(IDX_GAIN, 8'h0c);
        cmos_case("gain_6db_sat", 8'h00, 12'h800);
        wreg(IDX_FORMAT, 8'h03);
        settle();
        a = cap_cmos;
        @(posedge sample_clk);
        #1;
        b = cap_cmos;
        check("toggle_val", {31'h0, a === TOGGLE_A || a === TOGGLE_B}, 32'h1);
        check("toggle_alt", {20'h0, a ^ b}, 32'hfff);
        wreg(IDX_FORMAT, 8'h04);
        settle();
        a = cap_cmos;
        @(posedge sample_clk);
        #1;
        b = cap_cmos;
        check("ramp_step", {20'h0, b - a}, 32'h1);
        wreg(IDX_IFACE, 8'h20);
        for (int k = 0; k < 2; k++)
        begin
            wreg(IDX_FORMAT, {4'h0, k[0], 3'b101});
            settle();
            ex = lanes(USR_P, k[0]);
            check("lane_rise", {25'h0, cap_rise}, {25'h0, ex[13:7]});
            check("lane_fall", {25'h0, cap_fall}, {25'h0, ex[6:0]});
            check("cmos_off", {20'h0, cap_cmos}, 32'h0);
        end
        end_of_test();
    end
endmodule // tb_adc_output_format_test_gain
